// ### hw/sfb_defs.vh
/*
 * Constants of the status flag and bit operation unit: opcode fields,
 * status bit positions, control flag codes, stack size and pulse phases.
 * Assumes it is included by bare name from the design files.
 */
`ifndef SFB_DEFS_VH
`define SFB_DEFS_VH

`define SFB_WORD_W 16
`define SFB_STACK_DEPTH 16
`define SFB_FLAG_COUNT 8
`define SFB_STATUS_RESET 16'h0000

// Primary and secondary opcode fields.
`define SFB_OP_HI_NONE 5'h00
`define SFB_OP_HI_FLAG 5'h01
`define SFB_OP2_STATUS_SET 7'h70
`define SFB_OP2_STATUS_CLR 7'h71
`define SFB_OP2_ACC_SET 7'h72
`define SFB_OP2_ACC_CLR 7'h73
`define SFB_OP2_ACC_INV 7'h76
`define SFB_OP_FLAGS_SAVE 9'h001
`define SFB_OP_FLAGS_RESTORE 9'h005

// Status bit positions.
`define SFB_BIT_LINK 15
`define SFB_BIT_ARITH_RANGE 14
`define SFB_BIT_CARRY 13
`define SFB_BIT_IRQ3 12
`define SFB_BIT_IRQ2 8
`define SFB_BIT_IRQ1 4
`define SFB_BIT_IRQ0 0
`define SFB_HIDDEN_MASK 16'h0006

// Control flag codes; the flag address is the code plus eight.
`define SFB_FC_IRQ_ENABLE 3'h1
`define SFB_FC_BYTE_CHOICE 3'h2
`define SFB_FC_PANEL_GATE 3'h5
`define SFB_FLAG_ADDR_BASE 4'h8

// Pulse phases inside the microcycle, in clock cycles after issue.
`define SFB_PHASE_W 3
`define SFB_PHASE_T2 3'h2
`define SFB_PHASE_T6 3'h6

`endif

// ### hw/sfb_ctl_flag.v
/*
 * One external control flag: set by a set instruction, set at T2 and
 * cleared at T6 by a pulse, cleared by the byte choice clear.
 * Assumes the caller raises at most one request per cycle for this flag.
 */
`timescale 1ns/100ps
module sfb_ctl_flag (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Requests
    input wire set_hit,
    input wire pulse_t2,
    input wire pulse_t6,
    input wire clr_hit,
    // State
    output reg flag_q
);
    reg flag_d;

    always @* begin
        flag_d = flag_q;
        if (clr_hit || pulse_t6) begin
            flag_d = 1'b0;
        end
        // A set arriving with a clear wins so no event is lost.
        if (set_hit || pulse_t2) begin
            flag_d = 1'b1;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end
endmodule // sfb_ctl_flag

// ### hw/sfb_flag_stack.v
/*
 * Pushdown stack for the status flags. Entry 0 is the top and is a register,
 * so the top word comes straight from a flip-flop.
 * Assumes push, pull and clear are never requested together except clear.
 */
`timescale 1ns/100ps
`include "sfb_defs.vh"
module sfb_flag_stack #(
    parameter WIDTH = `SFB_WORD_W,
    parameter DEPTH = `SFB_STACK_DEPTH
) (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Commands
    input wire push_en,
    input wire pull_en,
    input wire clear_en,
    input wire [WIDTH-1:0] push_data,
    // Top of stack
    output wire [WIDTH-1:0] top_data
);
    reg [WIDTH-1:0] entry_q [0:DEPTH-1];
    genvar gi;

    assign top_data = entry_q[0];

    generate
        for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_level
            wire [WIDTH-1:0] above;
            wire [WIDTH-1:0] below;
            if (gi == 0) begin : g_top
                assign above = push_data;
            end else begin : g_mid
                assign above = entry_q[gi-1];
            end
            // Pulling fills the bottom level with zeros.
            if (gi == DEPTH-1) begin : g_bot
                assign below = {WIDTH{1'b0}};
            end else begin : g_up
                assign below = entry_q[gi+1];
            end
            always @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    entry_q[gi] <= {WIDTH{1'b0}};
                end else if (clear_en) begin
                    entry_q[gi] <= {WIDTH{1'b0}};
                end else if (push_en) begin
                    entry_q[gi] <= above;
                end else if (pull_en) begin
                    entry_q[gi] <= below;
                end
            end
        end
    endgenerate
endmodule // sfb_flag_stack

// ### hw/sfb_status_unit.v
/*
 * Status flag and bit manipulation unit: status register, accumulator zero,
 * status bit and accumulator bit instructions, flag save and restore through
 * the pushdown stack, and the external control flags.
 * Assumes the sequencer offers one instruction word with instr_valid and
 * holds it until instr_ready; all inputs are synchronous to clk.
 */
`timescale 1ns/100ps
`include "sfb_defs.vh"

// Functional notes
// - Flag codes 1, 2, 5 are interrupt enable, byte choice and panel gate; others user.
// - Set and pulse reach only flag addresses 8..15, code plus eight.
// - Opcode 1110000 sets status bit n and clears byte choice.
// - Opcode 1110001 clears status bit n and clears byte choice.
// - Opcode 1110010 sets accumulator zero bit n and clears byte choice.
// - Opcode 1110011 clears accumulator zero bit n and clears byte choice.
// - Opcode 1110110 inverts accumulator zero bit n and clears byte choice.
// - Flags save pushes the status word, bottom entry discarded.
// - Flags restore loads status from top, stack shifts up, bottom zero.
// - Status bit 15 is link, 14 overflow, 13 carry out.
// - Interrupt gates for levels 3, 2, 1, 0 sit at bits 12, 8, 4, 0.
// - Bits 11..9, 7..5, 3, 2, 1 are plain storage; 2 and 1 hidden from panel.
// - The stack is sixteen words deep and program load clears it.
// - A pulsed flag sets at T2 and clears at T6 of one microcycle.
// - Pulsing a flag already set leaves it cleared.
module sfb_status_unit #(
    parameter WIDTH = `SFB_WORD_W,
    parameter DEPTH = `SFB_STACK_DEPTH,
    parameter FLAGS = `SFB_FLAG_COUNT
) (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Instruction from the sequencer
    input wire instr_valid,
    input wire [15:0] instr_word,
    output wire instr_ready,
    output reg instr_done_q,
    output reg instr_illegal_q,
    // Program load control
    input wire program_load,
    // Direct status register access
    input wire status_we,
    input wire [WIDTH-1:0] status_wdata,
    // Arithmetic flag update
    input wire arith_we,
    input wire link_in,
    input wire arith_range_in,
    input wire carry_in,
    // Accumulator zero load
    input wire acc_we,
    input wire [WIDTH-1:0] acc_wdata,
    // Registers
    output reg [WIDTH-1:0] processor_status_flags_q,
    output reg [WIDTH-1:0] accumulator_zero_q,
    output wire [WIDTH-1:0] stack_top,
    output reg [WIDTH-1:0] panel_display_q,
    // Status fields
    output wire link_flag,
    output wire arith_range_flag,
    output wire carry_out_flag,
    output wire irq_level3_gate,
    output wire irq_level2_gate,
    output wire irq_level1_gate,
    output wire irq_level0_gate,
    // External control flags
    output wire [FLAGS-1:0] control_flags,
    output wire irq_enable_flag,
    output wire byte_choice_flag,
    output wire panel_interrupt_gate,
    output reg [3:0] flag_addr_q
);
    localparam ST_IDLE = 1'b0;
    localparam ST_PULSE = 1'b1;

    reg state_q;
    reg state_d;
    reg [`SFB_PHASE_W-1:0] phase_q;
    reg [`SFB_PHASE_W-1:0] phase_d;
    reg [2:0] pulse_code_q;
    reg [WIDTH-1:0] status_d;
    reg [WIDTH-1:0] acc_d;
    reg done_d;
    reg illegal_d;
    reg sel_clear;
    reg push_en;
    reg pull_en;
    reg [FLAGS-1:0] set_hit;
    reg [FLAGS-1:0] pulse_t2;
    reg [FLAGS-1:0] pulse_t6;
    reg [FLAGS-1:0] clr_hit;
    reg [3:0] flag_addr_d;

    wire take;
    wire [4:0] op_hi;
    wire [6:0] op2;
    wire [8:0] op_full;
    wire [3:0] bit_n;
    wire [2:0] flag_code;
    wire pulse_sel;
    wire dec_system;
    wire dec_save;
    wire dec_restore;
    wire dec_flag;
    wire dec_pulse;
    genvar gi;

    assign instr_ready = (state_q == ST_IDLE);
    assign take = instr_valid && instr_ready;
    assign op_hi = instr_word[15:11];
    assign op2 = instr_word[10:4];
    assign op_full = instr_word[15:7];
    assign bit_n = instr_word[3:0];
    assign flag_code = instr_word[10:8];
    assign pulse_sel = instr_word[7];

    // Field decode (op_hi, op_full, op2) keeps the priority chain below short and readable.
    assign dec_system = (op_hi == `SFB_OP_HI_NONE);
    assign dec_save = dec_system && (op_full == `SFB_OP_FLAGS_SAVE);
    assign dec_restore = dec_system && (op_full == `SFB_OP_FLAGS_RESTORE);
    assign dec_flag = (op_hi == `SFB_OP_HI_FLAG);
    assign dec_pulse = dec_flag && pulse_sel;

    assign link_flag = processor_status_flags_q[`SFB_BIT_LINK];
    assign arith_range_flag = processor_status_flags_q[`SFB_BIT_ARITH_RANGE];
    assign carry_out_flag = processor_status_flags_q[`SFB_BIT_CARRY];
    assign irq_level3_gate = processor_status_flags_q[`SFB_BIT_IRQ3];
    assign irq_level2_gate = processor_status_flags_q[`SFB_BIT_IRQ2];
    assign irq_level1_gate = processor_status_flags_q[`SFB_BIT_IRQ1];
    assign irq_level0_gate = processor_status_flags_q[`SFB_BIT_IRQ0];

    assign irq_enable_flag = control_flags[`SFB_FC_IRQ_ENABLE];
    assign byte_choice_flag = control_flags[`SFB_FC_BYTE_CHOICE];
    assign panel_interrupt_gate = control_flags[`SFB_FC_PANEL_GATE];

    // Instruction decode and execution; every update but a flag pulse lands in one cycle.
    always @* begin
        status_d = processor_status_flags_q;
        acc_d = accumulator_zero_q;
        done_d = 1'b0;
        illegal_d = 1'b0;
        sel_clear = 1'b0;
        push_en = 1'b0;
        pull_en = 1'b0;
        set_hit = {FLAGS{1'b0}};
        flag_addr_d = flag_addr_q;
        state_d = state_q;
        phase_d = phase_q;
        // Sequencer loads go first so an instruction in the same cycle overrides them.
        if (status_we) begin
            status_d = status_wdata;
        end
        if (arith_we) begin
            status_d[`SFB_BIT_LINK] = link_in;
            status_d[`SFB_BIT_ARITH_RANGE] = arith_range_in;
            status_d[`SFB_BIT_CARRY] = carry_in;
        end
        if (acc_we) begin
            acc_d = acc_wdata;
        end
        case (state_q)
            ST_IDLE: begin
                if (take) begin
                    done_d = 1'b1;
                    if (dec_save) begin
                        push_en = 1'b1;
                    end else if (dec_restore) begin
                        status_d = stack_top;
                        pull_en = 1'b1;
                    end else if (dec_system) begin
                        sel_clear = 1'b1;
                        case (op2)
                            `SFB_OP2_STATUS_SET: begin
                                status_d[bit_n] = 1'b1;
                            end
                            `SFB_OP2_STATUS_CLR: begin
                                status_d[bit_n] = 1'b0;
                            end
                            `SFB_OP2_ACC_SET: begin
                                acc_d[bit_n] = 1'b1;
                            end
                            `SFB_OP2_ACC_CLR: begin
                                acc_d[bit_n] = 1'b0;
                            end
                            `SFB_OP2_ACC_INV: begin
                                acc_d[bit_n] = ~accumulator_zero_q[bit_n];
                            end
                            default: begin
                                sel_clear = 1'b0;
                                illegal_d = 1'b1;
                            end
                        endcase
                    end else if (dec_flag) begin
                        flag_addr_d = `SFB_FLAG_ADDR_BASE | {1'b0, flag_code};
                        if (dec_pulse) begin
                            // The pulse holds the sequencer until T6 has passed.
                            done_d = 1'b0;
                            state_d = ST_PULSE;
                            phase_d = {`SFB_PHASE_W{1'b0}};
                        end else begin
                            set_hit[flag_code] = 1'b1;
                        end
                    end else begin
                        illegal_d = 1'b1;
                    end
                end
            end
            ST_PULSE: begin
                phase_d = phase_q + 1'b1;
                if (phase_q == `SFB_PHASE_T6) begin
                    state_d = ST_IDLE;
                    done_d = 1'b1;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Pulse phases and byte choice clear routed to each flag.
    always @* begin
        pulse_t2 = {FLAGS{1'b0}};
        pulse_t6 = {FLAGS{1'b0}};
        clr_hit = {FLAGS{1'b0}};
        if (state_q == ST_PULSE && phase_q == `SFB_PHASE_T2) begin
            pulse_t2[pulse_code_q] = 1'b1;
        end
        if (state_q == ST_PULSE && phase_q == `SFB_PHASE_T6) begin
            pulse_t6[pulse_code_q] = 1'b1;
        end
        if (sel_clear) begin
            clr_hit[`SFB_FC_BYTE_CHOICE] = 1'b1;
        end
    end

    generate
        for (gi = 0; gi < FLAGS; gi = gi + 1) begin : g_flag
            sfb_ctl_flag u_flag (
                .clk(clk),
                .rst_b(rst_b),
                .set_hit(set_hit[gi]),
                .pulse_t2(pulse_t2[gi]),
                .pulse_t6(pulse_t6[gi]),
                .clr_hit(clr_hit[gi]),
                .flag_q(control_flags[gi])
            );
        end
    endgenerate

    sfb_flag_stack #(
        .WIDTH(WIDTH),
        .DEPTH(DEPTH)
    ) u_stack (
        .clk(clk),
        .rst_b(rst_b),
        .push_en(push_en),
        .pull_en(pull_en),
        .clear_en(program_load),
        .push_data(processor_status_flags_q),
        .top_data(stack_top)
    );

    // Datapath registers.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            processor_status_flags_q <= `SFB_STATUS_RESET;
            accumulator_zero_q <= {WIDTH{1'b0}};
            panel_display_q <= {WIDTH{1'b0}};
        end else begin
            processor_status_flags_q <= status_d;
            accumulator_zero_q <= acc_d;
            // Hidden general bits never reach the panel lamps.
            panel_display_q <= status_d & ~`SFB_HIDDEN_MASK;
        end
    end

    // Flag addressing registers.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pulse_code_q <= 3'h0;
            flag_addr_q <= 4'h0;
        end else begin
            if (take && dec_flag) begin
                pulse_code_q <= flag_code;
            end
            flag_addr_q <= flag_addr_d;
        end
    end

    // Sequencing registers.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
            phase_q <= {`SFB_PHASE_W{1'b0}};
            instr_done_q <= 1'b0;
            instr_illegal_q <= 1'b0;
        end else begin
            state_q <= state_d;
            phase_q <= phase_d;
            instr_done_q <= done_d;
            instr_illegal_q <= illegal_d;
        end
    end
endmodule // sfb_status_unit

// ### bench/sfb_seq_model.sv
/*
 * Sequencer model: offers one instruction word at a time to the unit.
 * Assumes the unit takes a word on a rising edge with valid and ready high.
 */
`timescale 1ns/100ps
module sfb_seq_model (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Instruction handshake
    input wire instr_ready,
    output logic instr_valid,
    output logic [15:0] instr_word
);
    initial begin
        instr_valid = 1'b0;
        instr_word = 16'h0000;
    end

    // The word is held until ready is seen high at an edge; after release the
    // lines show the inverse so no stale value can pass for a held one.
    task automatic issue(input logic [15:0] w);
        logic rdy;
        @(posedge clk);
        #1;
        instr_valid = 1'b1;
        instr_word = w;
        // Ready is read mid-cycle, where it has settled, to judge the coming edge.
        do begin
            @(negedge clk);
            rdy = instr_ready;
            @(posedge clk);
        end while (rdy !== 1'b1);
        #1;
        instr_valid = 1'b0;
        instr_word = ~w;
    endtask
endmodule // sfb_seq_model

// ### bench/sfb_status_unit_sva.sv
/*
 * Checker for the status flag and bit operation unit.
 * Assumes it is bound to sfb_status_unit and sees only its ports.
 */
`timescale 1ns/100ps
`include "sfb_defs.vh"
module sfb_status_unit_chk #(
    parameter WIDTH = 16,
    parameter FLAGS = 8
) (
    // Ports watched
    input wire clk,
    input wire rst_b,
    input wire instr_valid,
    input wire [15:0] instr_word,
    input wire instr_ready,
    input wire instr_done_q,
    input wire acc_we,
    input wire program_load,
    input wire [WIDTH-1:0] processor_status_flags_q,
    input wire [WIDTH-1:0] accumulator_zero_q,
    input wire [WIDTH-1:0] stack_top,
    input wire [FLAGS-1:0] control_flags,
    input wire byte_choice_flag,
    input wire [3:0] flag_addr_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire take = instr_valid && instr_ready;
    wire [11:0] op = instr_word[15:4];

    a_status_set_bit: assert property (take && op == {5'h00, `SFB_OP2_STATUS_SET} |=>
        processor_status_flags_q[$past(instr_word[3:0])] && instr_done_q) else $error("status set failed");
    a_status_clr_bit: assert property (take && op == {5'h00, `SFB_OP2_STATUS_CLR} |=>
        !processor_status_flags_q[$past(instr_word[3:0])]) else $error("status clear failed");
    a_acc_bit_inv: assert property (take && !acc_we && op == {5'h00, `SFB_OP2_ACC_INV} |=>
        accumulator_zero_q == ($past(accumulator_zero_q) ^ (16'h0001 << $past(instr_word[3:0]))))
        else $error("acc invert failed");
    a_bit_op_sel: assert property (take && instr_word[15:11] == 5'h00 && instr_word[10:8] == 3'h7 &&
        instr_word[10:4] inside {`SFB_OP2_STATUS_SET, `SFB_OP2_STATUS_CLR, `SFB_OP2_ACC_SET, `SFB_OP2_ACC_CLR,
        `SFB_OP2_ACC_INV} |=> !byte_choice_flag) else $error("byte choice not cleared");
    a_save_top: assert property (take && !program_load && instr_word == {`SFB_OP_FLAGS_SAVE, 7'h00} |=>
        stack_top == $past(processor_status_flags_q)) else $error("save wrong");
    a_restore_status: assert property (take && instr_word == {`SFB_OP_FLAGS_RESTORE, 7'h00} |=>
        processor_status_flags_q == $past(stack_top)) else $error("restore wrong");
    a_pulse_ready_gap: assert property (take && instr_word[15:11] == `SFB_OP_HI_FLAG && instr_word[7] |=>
        !instr_ready [*7] ##1 (instr_ready && instr_done_q)) else $error("pulse timing wrong");
    a_pulse_flag_shape: assert property (take && instr_word[15:11] == `SFB_OP_HI_FLAG && instr_word[7] |=>
        ##3 control_flags[$past(instr_word[10:8], 4)] ##4 !control_flags[$past(instr_word[10:8], 8)])
        else $error("pulse shape wrong");
    a_set_flag_addr: assert property (take && instr_word[15:11] == `SFB_OP_HI_FLAG && !instr_word[7] |=>
        flag_addr_q == {1'b1, $past(instr_word[10:8])} && control_flags[$past(instr_word[10:8])])
        else $error("set flag wrong");
endmodule // sfb_status_unit_chk

bind sfb_status_unit sfb_status_unit_chk #(.WIDTH(WIDTH), .FLAGS(FLAGS)) u_chk (.clk(clk), .rst_b(rst_b),
    .instr_valid(instr_valid), .instr_word(instr_word), .instr_ready(instr_ready), .instr_done_q(instr_done_q),
    .acc_we(acc_we), .program_load(program_load), .processor_status_flags_q(processor_status_flags_q),
    .accumulator_zero_q(accumulator_zero_q), .stack_top(stack_top), .control_flags(control_flags),
    .byte_choice_flag(byte_choice_flag), .flag_addr_q(flag_addr_q));

// ### bench/tb_sfb_status_unit.sv
/*
 * Self-checking bench for the status flag and bit operation unit.
 * Assumes the sequencer model drives the instruction handshake.
 */
`timescale 1ns/100ps
`include "sfb_defs.vh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; \
    $display("ERROR %0t mismatch got %h exp %h", $time, (a), (e)); end end
module tb_sfb_status_unit;
    logic clk, rst_b, program_load, status_we, arith_we, link_in, arith_range_in, carry_in, acc_we;
    logic [15:0] status_wdata, acc_wdata, exp, v;
    wire instr_valid, instr_ready, instr_done_q, instr_illegal_q, link_flag, arith_range_flag, carry_out_flag;
    wire irq3, irq2, irq1, irq0, irq_enable_flag, byte_choice_flag, panel_interrupt_gate;
    wire [15:0] instr_word, processor_status_flags_q, accumulator_zero_q, stack_top, panel_display_q;
    wire [7:0] control_flags;
    wire [3:0] flag_addr_q;
    int errors = 0, checks = 0;
    logic [6:0] ops [3] = '{`SFB_OP2_ACC_SET, `SFB_OP2_ACC_CLR, `SFB_OP2_ACC_INV};

    sfb_seq_model seq (.clk(clk), .rst_b(rst_b), .instr_ready(instr_ready), .instr_valid(instr_valid),
        .instr_word(instr_word));
    sfb_status_unit uut (.clk(clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr_word(instr_word),
        .instr_ready(instr_ready), .instr_done_q(instr_done_q), .instr_illegal_q(instr_illegal_q),
        .program_load(program_load), .status_we(status_we), .status_wdata(status_wdata), .arith_we(arith_we),
        .link_in(link_in), .arith_range_in(arith_range_in), .carry_in(carry_in), .acc_we(acc_we),
        .acc_wdata(acc_wdata), .processor_status_flags_q(processor_status_flags_q),
        .accumulator_zero_q(accumulator_zero_q), .stack_top(stack_top), .panel_display_q(panel_display_q),
        .link_flag(link_flag), .arith_range_flag(arith_range_flag), .carry_out_flag(carry_out_flag),
        .irq_level3_gate(irq3), .irq_level2_gate(irq2), .irq_level1_gate(irq1), .irq_level0_gate(irq0),
        .control_flags(control_flags), .irq_enable_flag(irq_enable_flag), .byte_choice_flag(byte_choice_flag),
        .panel_interrupt_gate(panel_interrupt_gate), .flag_addr_q(flag_addr_q));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // One-cycle load strobe: 0 status, 1 accumulator, 2 arithmetic bits, 3 program load.
    task automatic ld(input int k, input logic [15:0] d);
        @(posedge clk);
        #1;
        {status_we, acc_we, arith_we, program_load} = 4'b1000 >> k;
        status_wdata = d;
        acc_wdata = d;
        {link_in, arith_range_in, carry_in} = d[15:13];
        @(posedge clk);
        #1;
        {status_we, acc_we, arith_we, program_load} = 4'h0;
    endtask

    // Byte choice is raised first so that its clearing by the bit operation is visible.
    task automatic bitop(input logic [6:0] o, input logic [3:0] n);
        seq.issue({`SFB_OP_HI_FLAG, `SFB_FC_BYTE_CHOICE, 8'h00});
        seq.issue({5'h00, o, n});
        `CHK(instr_done_q, 1'b1)
        `CHK(byte_choice_flag, 1'b0)
    endtask

    task automatic conclude;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #200000;
        errors++;
        conclude();
    end

    initial begin
        {rst_b, program_load, status_we, arith_we, link_in, arith_range_in, carry_in, acc_we} = 8'h00;
        status_wdata = 16'h0000;
        acc_wdata = 16'h0000;
        repeat (4) @(posedge clk);
        #1 rst_b = 1'b1;
        `CHK({processor_status_flags_q, stack_top, control_flags, instr_ready}, 41'h1)
        exp = 16'h0000;
        for (int n = 0; n < 16; n++) begin
            bitop(`SFB_OP2_STATUS_SET, n);
            exp[n] = 1'b1;
            `CHK(processor_status_flags_q, exp)
        end
        `CHK({link_flag, arith_range_flag, carry_out_flag, irq3, irq2, irq1, irq0}, 7'h7f)
        `CHK(panel_display_q, 16'hfff9)
        for (int n = 15; n >= 0; n--) begin
            bitop(`SFB_OP2_STATUS_CLR, n);
            exp[n] = 1'b0;
            `CHK(processor_status_flags_q, exp)
        end
        ld(2, 16'ha000);
        `CHK({link_flag, arith_range_flag, carry_out_flag}, 3'h5)
        ld(1, 16'h5a3c);
        exp = 16'h5a3c;
        for (int n = 0; n < 48; n++) begin
            bitop(ops[n % 3], n / 3);
            exp[n / 3] = (n % 3 == 0) ? 1'b1 : (n % 3 == 1) ? 1'b0 : ~exp[n / 3];
            `CHK(accumulator_zero_q, exp)
        end
        for (int fc = 0; fc < 8; fc++) begin
            seq.issue({`SFB_OP_HI_FLAG, fc[2:0], 8'h00});
            `CHK({control_flags[fc], flag_addr_q}, {1'b1, 4'h8 + fc[3:0]})
        end
        `CHK({irq_enable_flag, byte_choice_flag, panel_interrupt_gate}, 3'h7)
        for (int k = 0; k < 2; k++) begin
            seq.issue({`SFB_OP_HI_FLAG, 3'h3, 8'h80});
            `CHK(instr_ready, 1'b0)
            seq.issue({`SFB_OP_HI_FLAG, 3'h3, 8'h80});
            `CHK(control_flags[3], 1'b0)
        end
        for (int i = 0; i < 17; i++) begin
            ld(0, 16'h0101 * i + 16'h1);
            seq.issue({`SFB_OP_FLAGS_SAVE, 7'h00});
            `CHK(stack_top, 16'h0101 * i + 16'h1)
        end
        for (int i = 16; i >= 0; i--) begin
            seq.issue({`SFB_OP_FLAGS_RESTORE, 7'h00});
            v = (i == 0) ? 16'h0000 : 16'h0101 * i + 16'h1;
            `CHK(processor_status_flags_q, v)
        end
        ld(0, 16'h1234);
        seq.issue({`SFB_OP_FLAGS_SAVE, 7'h00});
        ld(3, 16'h0000);
        `CHK(stack_top, 16'h0000)
        seq.issue({`SFB_OP_FLAGS_RESTORE, 7'h00});
        `CHK(processor_status_flags_q, 16'h0000)
        seq.issue(16'hffff);
        `CHK({instr_illegal_q, processor_status_flags_q}, 17'h10000)
        conclude();
    end
endmodule // tb_sfb_status_unit
